// file: rtl/ccr_defines.svh
// register offsets, field positions and reset values of the channel calibration bank
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

`define CCR_ADDR_W 6
`define CCR_DATA_W 16

`define CCR_OFF_CH1_GAIN_HIGH 6'h11
`define CCR_OFF_CH1_GAIN_LOW 6'h12
`define CCR_OFF_CH2_CONFIG 6'h13
`define CCR_OFF_CH2_OFS_HIGH 6'h14
`define CCR_OFF_CH2_OFS_LOW 6'h15
`define CCR_OFF_CH2_GAIN_HIGH 6'h16
`define CCR_OFF_CH2_GAIN_LOW 6'h17

`define CCR_RST_CH1_GAIN_HIGH 16'h8000
`define CCR_RST_CH1_GAIN_LOW 16'h0000
`define CCR_RST_CH2_CONFIG 16'h0000
`define CCR_RST_CH2_OFS_HIGH 16'h0000
`define CCR_RST_CH2_OFS_LOW 16'h0000
`define CCR_RST_CH2_GAIN_HIGH 16'h8000
`define CCR_RST_CH2_GAIN_LOW 16'h0000

`define CCR_PHASE_MSB 15
`define CCR_PHASE_LSB 6
`define CCR_DCOFF_BIT 2
`define CCR_SEL_MSB 1
`define CCR_SEL_LSB 0
`define CCR_LOWREG_MSB 15
`define CCR_LOWREG_LSB 8
// writable bits of each register class
`define CCR_CFG_WMASK 16'hFFC7
`define CCR_LOW_WMASK 16'hFF00
`define CCR_FULL_WMASK 16'hFFFF

`endif

// file: rtl/ccr_pkg.sv
// types shared by the channel calibration register bank
package ccr_pkg;

	typedef enum logic [3:0] {
		CCR_IN_EXTERNAL = 4'h1,
		CCR_IN_SHORTED = 4'h2,
		CCR_IN_TEST_POS = 4'h4,
		CCR_IN_TEST_NEG = 4'h8
	} ccr_input_route_t;

	typedef struct packed {
		logic [15:0] ch1_gain_cal_high;
		logic [15:0] ch1_gain_cal_low;
		logic [15:0] ch2_config;
		logic [15:0] ch2_offset_cal_high;
		logic [15:0] ch2_offset_cal_low;
		logic [15:0] ch2_gain_cal_high;
		logic [15:0] ch2_gain_cal_low;
		logic [15:0] rd_data;
	} ccr_state_t;

	typedef struct packed {
		logic signed [9:0] ch2_phase_delay;
		logic ch2_dc_filter_bypass;
		ccr_input_route_t ch2_route;
		logic [23:0] ch2_offset_cal;
		logic [23:0] ch2_gain_cal;
		logic [23:0] ch1_gain_cal;
	} ccr_channel_ctrl_t;

endpackage

// file: rtl/ccr_input_route.sv
// decoder of the two-bit channel input selector into a one-hot route
`timescale 1ns/1ns
`default_nettype none
module ccr_input_route
	import ccr_pkg::*;
(
	// selector from the configuration word
	input wire logic [1:0] sel,
	// one-hot route to the analog switches
	output ccr_input_route_t route
);

	always_comb begin
		unique case (sel)
			2'h0: route = CCR_IN_EXTERNAL;
			2'h1: route = CCR_IN_SHORTED;
			2'h2: route = CCR_IN_TEST_POS;
			2'h3: route = CCR_IN_TEST_NEG;
		endcase
	end

endmodule
`default_nettype wire

// file: rtl/ccr_channel_cal_regs.sv
// channel 1 gain and channel 2 configuration and calibration register bank
`timescale 1ns/1ns
`default_nettype none
`include "ccr_defines.svh"

module ccr_channel_cal_regs
	import ccr_pkg::*;
#(
	parameter int ADDR_W = `CCR_ADDR_W,
	parameter int DATA_W = `CCR_DATA_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access from the command decoder
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_hit,
	// global DC filter control from the rest of the device
	input wire logic global_dc_filter_setting,
	// channel controls toward the converter
	output ccr_channel_ctrl_t chan_ctrl,
	output logic ch2_dc_filter_active
);

	// ************************************************************
	// parameter checks
	// ************************************************************
	// the read mux and masks are 16 bits wide; offsets up to 0x17 need five address bits
	if (DATA_W != 16 || ADDR_W < 5) begin : g_bad_width
		$error("ccr_channel_cal_regs: unsupported bus widths");
	end

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [15:0] wmask);
		merge = (old_v & ~wmask) | (new_v & wmask);
	endfunction

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [5:0] off);
		addr_is = (a == ADDR_W'(off));
	endfunction

	ccr_state_t state_reg;
	ccr_state_t state_next;
	logic [15:0] wdata;
	logic mapped;

	assign wdata = reg_wdata[15:0];

	// ************************************************************
	// register update and read mux
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		mapped = 1'b1;
		if (addr_is(reg_addr, `CCR_OFF_CH1_GAIN_HIGH)) begin
			if (reg_wr)
				state_next.ch1_gain_cal_high = merge(state_reg.ch1_gain_cal_high, wdata,
					`CCR_FULL_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch1_gain_cal_high;
		end else if (addr_is(reg_addr, `CCR_OFF_CH1_GAIN_LOW)) begin
			if (reg_wr)
				state_next.ch1_gain_cal_low = merge(state_reg.ch1_gain_cal_low, wdata,
					`CCR_LOW_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch1_gain_cal_low;
		end else if (addr_is(reg_addr, `CCR_OFF_CH2_CONFIG)) begin
			// reserved bits 5:3 stay zero
			if (reg_wr)
				state_next.ch2_config = merge(state_reg.ch2_config, wdata,
					`CCR_CFG_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch2_config;
		end else if (addr_is(reg_addr, `CCR_OFF_CH2_OFS_HIGH)) begin
			if (reg_wr)
				state_next.ch2_offset_cal_high = merge(state_reg.ch2_offset_cal_high, wdata,
					`CCR_FULL_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch2_offset_cal_high;
		end else if (addr_is(reg_addr, `CCR_OFF_CH2_OFS_LOW)) begin
			if (reg_wr)
				state_next.ch2_offset_cal_low = merge(state_reg.ch2_offset_cal_low, wdata,
					`CCR_LOW_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch2_offset_cal_low;
		end else if (addr_is(reg_addr, `CCR_OFF_CH2_GAIN_HIGH)) begin
			if (reg_wr)
				state_next.ch2_gain_cal_high = merge(state_reg.ch2_gain_cal_high, wdata,
					`CCR_FULL_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch2_gain_cal_high;
		end else if (addr_is(reg_addr, `CCR_OFF_CH2_GAIN_LOW)) begin
			if (reg_wr)
				state_next.ch2_gain_cal_low = merge(state_reg.ch2_gain_cal_low, wdata,
					`CCR_LOW_WMASK);
			if (reg_rd)
				state_next.rd_data = state_reg.ch2_gain_cal_low;
		end else begin
			// other offsets belong to neighbouring banks; answer zero
			mapped = 1'b0;
			if (reg_rd)
				state_next.rd_data = 16'h0000;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg.ch1_gain_cal_high <= `CCR_RST_CH1_GAIN_HIGH;
			state_reg.ch1_gain_cal_low <= `CCR_RST_CH1_GAIN_LOW;
			state_reg.ch2_config <= `CCR_RST_CH2_CONFIG;
			state_reg.ch2_offset_cal_high <= `CCR_RST_CH2_OFS_HIGH;
			state_reg.ch2_offset_cal_low <= `CCR_RST_CH2_OFS_LOW;
			state_reg.ch2_gain_cal_high <= `CCR_RST_CH2_GAIN_HIGH;
			state_reg.ch2_gain_cal_low <= `CCR_RST_CH2_GAIN_LOW;
			state_reg.rd_data <= 16'h0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rd_data;
	assign reg_hit = mapped;

	// ************************************************************
	// channel controls
	// ************************************************************
	ccr_input_route_t route;

	ccr_input_route u_route (
		.sel(state_reg.ch2_config[`CCR_SEL_MSB:`CCR_SEL_LSB]),
		.route(route)
	);

	always_comb begin
		chan_ctrl.ch2_phase_delay =
			$signed(state_reg.ch2_config[`CCR_PHASE_MSB:`CCR_PHASE_LSB]);
		chan_ctrl.ch2_dc_filter_bypass = state_reg.ch2_config[`CCR_DCOFF_BIT];
		chan_ctrl.ch2_route = route;
		chan_ctrl.ch2_offset_cal = {state_reg.ch2_offset_cal_high,
			state_reg.ch2_offset_cal_low[`CCR_LOWREG_MSB:`CCR_LOWREG_LSB]};
		chan_ctrl.ch2_gain_cal = {state_reg.ch2_gain_cal_high,
			state_reg.ch2_gain_cal_low[`CCR_LOWREG_MSB:`CCR_LOWREG_LSB]};
		chan_ctrl.ch1_gain_cal = {state_reg.ch1_gain_cal_high,
			state_reg.ch1_gain_cal_low[`CCR_LOWREG_MSB:`CCR_LOWREG_LSB]};
	end

	// bypass overrides the global filter enable
	assign ch2_dc_filter_active = global_dc_filter_setting &
		~state_reg.ch2_config[`CCR_DCOFF_BIT];

endmodule
`default_nettype wire

// file: verification/ccr_host_model.sv
// host model issuing register requests into the bank
`timescale 1ns/1ns
`default_nettype none
module ccr_host_model (
	// clock
	input wire logic clk,
	// register requests
	output logic reg_wr,
	output logic reg_rd,
	output logic [5:0] reg_addr,
	output logic [15:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	// strobes stay up between calls so back-to-back requests never glitch
	task automatic xfer(input bit w, input bit r, input logic [5:0] a, input logic [15:0] d);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
		@(negedge clk);
	endtask
	// released data lines do not keep their last value
	task automatic idle();
		{reg_wr, reg_rd} = 2'b00;
		reg_wdata = ~reg_wdata;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// file: verification/ccr_cal_checker_assertions.sv
// port assertions for the channel calibration register bank
`timescale 1ns/1ns
`default_nettype none
module ccr_cal_checker
	import ccr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_hit,
	// channel side
	input wire logic global_dc_filter_setting,
	input wire ccr_channel_ctrl_t chan_ctrl,
	input wire logic ch2_dc_filter_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence wr_at(logic [5:0] a);
		reg_wr && reg_addr == a;
	endsequence
	phase_delay_a: assert property (wr_at(6'h13) |=>
		chan_ctrl.ch2_phase_delay == $past(reg_wdata[15:6])) else $error("phase delay wrong");
	dc_bypass_a: assert property (wr_at(6'h13) |=>
		ch2_dc_filter_active == (global_dc_filter_setting && !$past(reg_wdata[2])))
		else $error("dc filter wrong");
	input_route_a: assert property (wr_at(6'h13) |=>
		chan_ctrl.ch2_route == 4'h1 << $past(reg_wdata[1:0])) else $error("route wrong");
	offset_high_a: assert property (wr_at(6'h14) |=>
		chan_ctrl.ch2_offset_cal[23:8] == $past(reg_wdata)) else $error("offset high wrong");
	gain_high_a: assert property (wr_at(6'h16) |=>
		chan_ctrl.ch2_gain_cal[23:8] == $past(reg_wdata)) else $error("gain high wrong");
	gain_low_a: assert property (wr_at(6'h17) |=>
		chan_ctrl.ch2_gain_cal[7:0] == $past(reg_wdata[15:8])) else $error("gain low wrong");
	ch1_low_a: assert property (wr_at(6'h12) |=>
		chan_ctrl.ch1_gain_cal[7:0] == $past(reg_wdata[15:8])) else $error("ch1 low wrong");
	ch1_high_a: assert property (wr_at(6'h11) |=>
		chan_ctrl.ch1_gain_cal[23:8] == $past(reg_wdata)) else $error("ch1 high wrong");
	offset_low_a: assert property (wr_at(6'h15) |=>
		chan_ctrl.ch2_offset_cal[7:0] == $past(reg_wdata[15:8])) else $error("offset low wrong");
	low_zero_a: assert property (reg_rd && reg_addr inside {6'h12, 6'h15, 6'h17} |=>
		reg_rdata[7:0] == 8'h00) else $error("reserved byte not zero");
endmodule
bind ccr_channel_cal_regs ccr_cal_checker ccr_cal_checker_inst (.*);
`default_nettype wire

// file: verification/channel_cal_config_regs_tb_top.sv
// self-checking bench for the channel calibration register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", n, e, a); end end
module channel_cal_config_regs_tb_top
	import ccr_pkg::*;
;
	logic clk = 0, rst = 1, gdc = 0, reg_wr, reg_rd, reg_hit, act;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, eq = 16'h0000;
	ccr_channel_ctrl_t c;
	int fail_count = 0, n_tests = 0;
	logic [15:0] m [17:23] = '{16'h8000, 0, 0, 0, 0, 16'h8000, 0};
	always #4 clk = ~clk;
	ccr_host_model ccr_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	ccr_channel_cal_regs ccr_channel_cal_regs_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .global_dc_filter_setting(gdc), .chan_ctrl(c),
		.ch2_dc_filter_active(act));
	function automatic logic [15:0] wmask(int a);
		return a == 19 ? 16'hFFC7 : a inside {18, 21, 23} ? 16'hFF00 : 16'hFFFF;
	endfunction
	task automatic tally_and_finish();
		if (fail_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// the loop needs about 4 us including the mid-run reset; twenty leaves plenty of slack
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		int a;
		bit w, r;
		logic [15:0] d;
		void'($urandom(7746));
		repeat (8) @(negedge clk);
		rst = 0;
		// first seven passes read every register straight out of reset
		for (int i = 0; i < 300; i++) begin
			// a second reset mid-run must bring every register back to its reset value
			if (i == 150) begin
				rst = 1;
				repeat (2) @(negedge clk);
				rst = 0;
				m = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
				eq = 16'h0000;
			end
			a = i < 7 ? 17 + i : 16 + int'($urandom_range(8));
			w = i >= 7 && $urandom_range(1);
			r = i < 7 || $urandom_range(1);
			d = 16'($urandom);
			gdc = 1'($urandom);
			ccr_host_model_inst.xfer(w, r, a[5:0], d);
			if (r) eq = a inside {[17:23]} ? m[a] : 16'h0000;
			if (w && a inside {[17:23]}) m[a] = d & wmask(a);
			`CHK("rdata", eq, reg_rdata)
			`CHK("hit", a inside {[17:23]}, reg_hit)
			`CHK("phase", m[19][15:6], c.ch2_phase_delay)
			`CHK("dc", gdc & ~m[19][2], act)
			`CHK("bypass", m[19][2], c.ch2_dc_filter_bypass)
			`CHK("route", 4'h1 << m[19][1:0], c.ch2_route)
			`CHK("ocal", {m[20], m[21][15:8]}, c.ch2_offset_cal)
			`CHK("gcal2", {m[22], m[23][15:8]}, c.ch2_gain_cal)
			`CHK("gcal1", {m[17], m[18][15:8]}, c.ch1_gain_cal)
			if ($urandom_range(1)) ccr_host_model_inst.idle();
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
